// [issue_model.sv]
// Issue logic and register file stand-in: presents one request, returns its write-back.
// Assumes one clock; the caller waits for the design's reset to clear first.
`timescale 1ns/10ps
`default_nettype none
module issue_model
  import simd_datapath_pkg::*;
(
  input  wire logic       mclk,
  output var request_type request,
  input  wire result_type result
);
  // Idle bus carries no valid
  initial request = '0;

  // Drive just after an edge, hold one edge, take the answer just after that same edge
  task automatic send(input op_type op, input logic wide, input logic [7:0] imm,
                      input logic [4:0] dest, input logic [127:0] a, input logic [127:0] b,
                      output result_type r);
    @(posedge mclk);
    #1 request = '{1'b1, op, wide, dest, imm, a, b};
    @(posedge mclk);
    // Released operands flip so stale data never looks valid
    #1 request.valid = 1'b0;
    request.src_a = ~a;
    request.src_b = ~b;
    r = result;
  endtask
endmodule // issue_model
`default_nettype wire

// [simd_datapath.sv]
// Packed integer SIMD execution datapath: multiply-add, widening multiply,
// quadword add/subtract, byte shifts and low interleave.
// Assumes requests come from issue logic on mclk; results return one cycle later.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Multiply-add forms signed 16-bit products and sums adjacent pairs.
// - Multiply-add results are packed 32-bit dwords, two per 64 bits.
// - Widening multiply takes low dword of each lane, unsigned, full 64-bit product.
// - Widening multiply has 64-bit and 128-bit forms; 128-bit does two lanes.
// - Quadword add/subtract works per 64-bit lane into matching destination lane.
// - One binary add/subtract serves signed and unsigned operands alike.
// - Quadword overflow keeps low 64 bits, no saturation, no cross-lane carry.
// - Quadword add/subtract has 64-bit and 128-bit forms, lanes independent.
// - Byte shifts move whole 128-bit operand by immediate bytes, zero fill.
// - Byte shift count above fifteen yields an all-zero destination.
// - Low interleave of a register with itself repeats its low dword twice.
module simd_datapath
  import simd_datapath_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire request_type request,
  output var  result_type  result
);

  // Whole module state in one struct
  typedef struct packed {
    logic [1:0] reset_sync;
    result_type out;
  } state_type;

  state_type state;
  state_type next_state;
  logic      reset_int_n;

  assign reset_int_n = state.reset_sync[1];

  // Signed 16x16 products of adjacent pairs summed into one dword
  function automatic logic [31:0] madd_pair(input logic [31:0] a, input logic [31:0] b);
    logic signed [31:0] p0;
    logic signed [31:0] p1;
    p0 = $signed(a[15:0]) * $signed(b[15:0]);
    p1 = $signed(a[31:16]) * $signed(b[31:16]);
    return 32'(p0 + p1);
  endfunction

  // Unsigned low dword times low dword, full width kept
  function automatic logic [63:0] umul_lane(input logic [63:0] a, input logic [63:0] b);
    return 64'(a[31:0]) * 64'(b[31:0]);
  endfunction

  // Same adder for signed and unsigned; carry out dropped
  function automatic logic [63:0] qaddsub(input logic [63:0] a, input logic [63:0] b,
                                          input logic sub);
    return sub ? 64'(a - b) : 64'(a + b);
  endfunction

  logic [127:0] alu;
  logic [7:0]   shamt;
  logic         upper_on;

  // Operation datapath
  always_comb
  begin
    alu      = RESULT_RESET;
    shamt    = request.imm;
    upper_on = request.wide;
    unique case (request.op)
      op_word_multiply_add:
      begin
        for (int i = 0; i < 4; i++)
        begin
          alu[i*32 +: 32] = madd_pair(request.src_a[i*32 +: 32],
                                      request.src_b[i*32 +: 32]);
        end
      end
      op_unsigned_widening_multiply:
      begin
        alu[63:0]   = umul_lane(request.src_a[63:0], request.src_b[63:0]);
        alu[127:64] = umul_lane(request.src_a[127:64], request.src_b[127:64]);
      end
      op_quadword_add, op_quadword_subtract:
      begin
        for (int i = 0; i < 2; i++)
        begin
          alu[i*64 +: 64] = qaddsub(request.src_a[i*64 +: 64], request.src_b[i*64 +: 64],
                                    request.op == op_quadword_subtract);
        end
      end
      op_byte_shift_left:
      begin
        upper_on = 1'b1;
        if (shamt > SHIFT_LIMIT)
          alu = RESULT_RESET;
        else
          alu = request.src_a << {shamt[3:0], 3'b000};
      end
      op_byte_shift_right:
      begin
        upper_on = 1'b1;
        if (shamt > SHIFT_LIMIT)
          alu = RESULT_RESET;
        else
          alu = request.src_a >> {shamt[3:0], 3'b000};
      end
      op_low_dword_interleave:
      begin
        // Interleave low dwords of each source; same source duplicates them
        alu[63:0]   = {request.src_b[31:0], request.src_a[31:0]};
        alu[127:64] = {request.src_b[63:32], request.src_a[63:32]};
      end
      default:
      begin
        alu = RESULT_RESET;
      end
    endcase
    // 64-bit forms leave the upper half clear
    if (!upper_on)
      alu[127:64] = 64'h0000_0000_0000_0000;
  end

  // Next state: reset synchroniser shift and registered result
  always_comb
  begin
    next_state                = state;
    next_state.reset_sync     = {state.reset_sync[0], 1'b1};
    next_state.out.valid      = request.valid && (request.op != op_none);
    next_state.out.dest       = request.dest;
    next_state.out.data       = alu;
    if (!reset_int_n)
    begin
      next_state.out = '0;   // Hold results quiet until reset fully released
    end
  end

  // Single register stage; async reset clears to constants only
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign result = state.out;

  // Checks
  sequence s_issue(op_type o);
    request.valid && request.op == o;
  endsequence

  a_qadd_low_lane: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_quadword_add) |=> result.data[63:0] ==
      64'($past(request.src_a[63:0]) + $past(request.src_b[63:0])))
    else $error("quadword add low lane wrong");

  a_qsub_high_lane: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_quadword_subtract) ##0 request.wide |=> result.data[127:64] ==
      64'($past(request.src_a[127:64]) - $past(request.src_b[127:64])))
    else $error("quadword subtract high lane wrong");

  a_narrow_upper_zero: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_unsigned_widening_multiply) ##0 !request.wide |=> result.data[127:64] == 0)
    else $error("64-bit form upper half not clear");

  a_umul_full: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_unsigned_widening_multiply) |=> result.data[63:0] ==
      64'($past(request.src_a[31:0])) * 64'($past(request.src_b[31:0])))
    else $error("widening multiply low lane wrong");

  a_shift_over_zero: assert property (@(posedge mclk) disable iff (!reset_int_n)
    (s_issue(op_byte_shift_left) or s_issue(op_byte_shift_right)) ##0 request.imm > SHIFT_LIMIT
      |=> result.valid && result.data == 0)
    else $error("oversize byte shift not zero");

  a_shift_left_zero: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_byte_shift_left) ##0 request.imm == 8'h01 |=> result.data[7:0] == 8'h00 &&
      result.data[127:8] == $past(request.src_a[119:0]))
    else $error("byte shift left fill wrong");

  a_madd_dword: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_word_multiply_add) |=> result.data[31:0] ==
      32'($signed($past(request.src_a[15:0])) * $signed($past(request.src_b[15:0]))
        + $signed($past(request.src_a[31:16])) * $signed($past(request.src_b[31:16]))))
    else $error("multiply-add dword wrong");

  a_interleave_dup: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_low_dword_interleave) ##0 request.src_a == request.src_b
      |=> result.data[63:32] == result.data[31:0])
    else $error("interleave did not duplicate");

  // Any accepted operation, whatever its code
  sequence s_accept;
    request.valid && request.op != op_none;
  endsequence

  // High quad lane of the wide add, carry from the low lane must not leak
  a_qadd_high_lane: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_quadword_add) ##0 request.wide |=> result.data[127:64] ==
      64'($past(request.src_a[127:64]) + $past(request.src_b[127:64])))
    else $error("quadword add high lane wrong");

  // Low lane subtract wraps modulo 2^64
  a_qsub_low_lane: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_quadword_subtract) |=> result.data[63:0] ==
      64'($past(request.src_a[63:0]) - $past(request.src_b[63:0])))
    else $error("quadword subtract low lane wrong");

  // Narrow add leaves the upper half clear
  a_qadd_narrow_zero: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_quadword_add) ##0 !request.wide |=> result.data[127:64] == 0)
    else $error("narrow quadword add upper half not clear");

  // Narrow subtract leaves the upper half clear
  a_qsub_narrow_zero: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_quadword_subtract) ##0 !request.wide |=> result.data[127:64] == 0)
    else $error("narrow quadword subtract upper half not clear");

  // Wide multiply uses the low dword of the high lane only
  a_umul_high_lane: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_unsigned_widening_multiply) ##0 request.wide |=> result.data[127:64] ==
      64'($past(request.src_a[95:64])) * 64'($past(request.src_b[95:64])))
    else $error("widening multiply high lane wrong");

  // Second dword of the multiply-add
  a_madd_second_dword: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_word_multiply_add) |=> result.data[63:32] ==
      32'($signed($past(request.src_a[47:32])) * $signed($past(request.src_b[47:32]))
        + $signed($past(request.src_a[63:48])) * $signed($past(request.src_b[63:48]))))
    else $error("multiply-add second dword wrong");

  // Top dword of the wide multiply-add, signed products
  a_madd_high_dword: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_word_multiply_add) ##0 request.wide |=> result.data[127:96] ==
      32'($signed($past(request.src_a[111:96])) * $signed($past(request.src_b[111:96]))
        + $signed($past(request.src_a[127:112])) * $signed($past(request.src_b[127:112]))))
    else $error("multiply-add high dword wrong");

  // Right shift by one byte clears the top byte
  a_shift_right_fill: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_byte_shift_right) ##0 request.imm == 8'h01 |=> result.data[127:120] == 8'h00 &&
      result.data[119:0] == $past(request.src_a[127:8]))
    else $error("byte shift right fill wrong");

  // Largest legal count keeps only the lowest byte
  a_shift_max_left: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_byte_shift_left) ##0 request.imm == 8'h0F |=> result.data[119:0] == 0 &&
      result.data[127:120] == $past(request.src_a[7:0]))
    else $error("byte shift left by fifteen wrong");

  // Top of the count range still zero, not folded by the low nibble
  a_shift_right_over: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_byte_shift_right) ##0 request.imm == 8'hFF |=> result.data == 0)
    else $error("byte shift right by 255 not zero");

  // Sixteen is the first count that clears everything
  a_shift_left_over: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_byte_shift_left) ##0 request.imm == 8'h10 |=> result.data == 0)
    else $error("byte shift left by sixteen not zero");

  // Low dword of the interleave comes from the first source
  a_interleave_low: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_low_dword_interleave) |=> result.data[31:0] == $past(request.src_a[31:0]))
    else $error("interleave low dword wrong");

  // Upper pair repeats too when both sources match
  a_interleave_high: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_issue(op_low_dword_interleave) ##0 request.src_a == request.src_b
      |=> result.data[127:96] == result.data[95:64])
    else $error("interleave upper pair did not duplicate");

  // Every accepted op writes back exactly one cycle later
  a_write_back_valid: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_accept |=> result.valid)
    else $error("accepted operation gave no write-back");

  // Destination tag echoed so the register file writes the right lane set
  a_dest_echo: assert property (@(posedge mclk) disable iff (!reset_int_n)
    s_accept |=> result.dest == $past(request.dest))
    else $error("destination tag not echoed");

  // No request, no write-back; a stray write would corrupt a register
  a_idle_quiet: assert property (@(posedge mclk) disable iff (!reset_int_n)
    !(request.valid && request.op != op_none) |=> !result.valid)
    else $error("write-back without a request");

  // Held quiet while the internal reset is still asserted
  a_reset_quiet: assert property (@(posedge mclk)
    !reset_int_n |=> !result.valid)
    else $error("write-back during reset");

endmodule // simd_datapath

`default_nettype wire

// [simd_datapath_pkg.sv]
// Package for the packed integer SIMD datapath: opcodes, widths, request/result carriers.
// Assumes a single core clock domain; issue logic and register file sit outside.
package simd_datapath_pkg;

  localparam int unsigned REG_WIDTH    = 128;
  localparam int unsigned LANE_WIDTH   = 64;
  localparam int unsigned DWORD_WIDTH  = 32;
  localparam int unsigned WORD_WIDTH   = 16;
  localparam int unsigned BYTE_COUNT   = 16;
  localparam logic [7:0]  SHIFT_LIMIT  = 8'h0F;
  localparam logic [127:0] RESULT_RESET = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
  localparam logic [3:0]  OP_RESET     = 4'h0;
  localparam int unsigned LATENCY_CYCLES = 1;

  // Operation select from issue logic
  typedef enum logic [3:0] {
    op_none                      = 4'h0,
    op_word_multiply_add         = 4'h1,
    op_unsigned_widening_multiply = 4'h2,
    op_quadword_add              = 4'h3,
    op_quadword_subtract         = 4'h4,
    op_byte_shift_left           = 4'h5,
    op_byte_shift_right          = 4'h6,
    op_low_dword_interleave      = 4'h7
  } op_type;

  // One issued operation
  typedef struct packed {
    logic         valid;
    op_type       op;
    logic         wide;       // 1: 128-bit form, 0: 64-bit form
    logic [4:0]   dest;
    logic [7:0]   imm;
    logic [127:0] src_a;
    logic [127:0] src_b;
  } request_type;

  // One write-back to the register file
  typedef struct packed {
    logic         valid;
    logic [4:0]   dest;
    logic [127:0] data;
  } result_type;

endpackage

// [tb_packed_integer_simd_datapath.sv]
// Self-checking bench for the packed integer SIMD datapath.
// Assumes the issue model drives requests; one-cycle answer latency.
`timescale 1ns/10ps
`default_nettype none
module tb_packed_integer_simd_datapath;
  import simd_datapath_pkg::*;
  logic        mclk;
  logic        reset_n;
  request_type request;
  result_type  result;
  int          err_count;
  int          checks_done;

  simd_datapath simd_datapath_inst (.mclk(mclk), .reset_n(reset_n), .request(request),
                                    .result(result));
  issue_model issue_model_inst (.mclk(mclk), .request(request), .result(result));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Expected write-back data
  function automatic logic [127:0] expect_of(op_type op, logic wide, logic [7:0] imm,
                                             logic [127:0] a, logic [127:0] b);
    logic [127:0] e;
    e = '0;
    for (int i = 0; i < 4; i++)
      if (op == op_word_multiply_add)
        e[32*i+:32] = $signed(a[32*i+:16]) * $signed(b[32*i+:16])
                    + $signed(a[32*i+16+:16]) * $signed(b[32*i+16+:16]);
    for (int i = 0; i < 2; i++)
      case (op)
        op_unsigned_widening_multiply: e[64*i+:64] = a[64*i+:32] * b[64*i+:32];
        op_quadword_add:               e[64*i+:64] = a[64*i+:64] + b[64*i+:64];
        op_quadword_subtract:          e[64*i+:64] = a[64*i+:64] - b[64*i+:64];
        default: ;
      endcase
    if (op == op_byte_shift_left) e = (imm > 8'h0F) ? '0 : a << {imm[3:0], 3'b000};
    if (op == op_byte_shift_right) e = (imm > 8'h0F) ? '0 : a >> {imm[3:0], 3'b000};
    if (op == op_low_dword_interleave) e = {b[63:32], a[63:32], b[31:0], a[31:0]};
    // Narrow form leaves the upper half clear
    if (!wide && op inside {op_word_multiply_add, op_unsigned_widening_multiply, op_quadword_add,
                            op_quadword_subtract}) e[127:64] = '0;
    return e;
  endfunction

  // One operation, judged on valid, tag and data
  task automatic check(op_type op, logic wide, logic [7:0] imm, logic [127:0] a, logic [127:0] b);
    result_type r;
    issue_model_inst.send(op, wide, imm, checks_done[4:0], a, b, r);
    checks_done++;
    if (r.valid !== 1'b1 || r.dest !== checks_done[4:0] - 5'h01
        || r.data !== expect_of(op, wide, imm, a, b))
    begin
      err_count++;
      $display("BAD %0t op %0d result mismatch", $time, op);
    end
  endtask

  task automatic t_madd();
    for (int w = 0; w < 2; w++)
      check(op_word_multiply_add, w[0], 8'h00, 128'h8000_7fff_ffff_0001_1234_8000_0002_fffe,
            128'h8000_8000_0003_ffff_7fff_8000_fffd_0005);
    $display("multiply-add done");
  endtask

  task automatic t_umul();
    for (int w = 0; w < 2; w++)
      check(op_unsigned_widening_multiply, w[0], 8'h00, {2{64'h1234_5678_ffff_ffff}},
            128'h8765_4321_ffff_fffe_0000_0001_ffff_ffff);
    $display("widening multiply done");
  endtask

  task automatic t_quad();
    for (int w = 0; w < 4; w++)
      check(w[1] ? op_quadword_subtract : op_quadword_add, w[0], 8'h00,
            128'hffff_ffff_ffff_ffff_8000_0000_0000_0000,
            128'h0000_0000_0000_0002_8000_0000_0000_0001);
    $display("quadword add and subtract done");
  endtask

  task automatic t_shift();
    logic [7:0] counts [5] = '{8'h00, 8'h01, 8'h0F, 8'h10, 8'hFF};
    for (int i = 0; i < 10; i++)
      check(i[0] ? op_byte_shift_right : op_byte_shift_left, 1'b1, counts[i/2],
            128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, '0);
    $display("byte shifts done");
  endtask

  task automatic t_misc();
    result_type r;
    check(op_low_dword_interleave, 1'b1, 8'h00, {2{64'hdead_beef_0a0b_0c0d}},
          {2{64'hdead_beef_0a0b_0c0d}});
    issue_model_inst.send(op_none, 1'b1, 8'h00, 5'h1F, '1, '1, r);
    checks_done++;
    if (r.valid !== 1'b0)
    begin
      err_count++;
      $display("BAD %0t empty operation produced a write-back", $time);
    end
    $display("interleave and empty operation done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence: reset, settle, scenarios
  initial begin
    err_count = 0;
    checks_done = 0;
    reset_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    t_madd();
    t_umul();
    t_quad();
    t_shift();
    t_misc();
    conclude();
  end

  // Hang guard, far beyond the few dozen cycles the scenarios need
  initial begin
    #20000;
    err_count++;
    conclude();
  end
endmodule // tb_packed_integer_simd_datapath
`default_nettype wire
